/* rtl/mdc_pkg.sv */
/*
 * Constants, register map and state encodings of the multichannel
 * transfer engine.
 * Assumes a 32-bit AXI4-Lite register port and a 16-bit data space.
 */
package mdc_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int unsigned NUM_CH = 6; // Channels in the engine.
	localparam int unsigned GROUP0_N = 4; // Channels gated by group 0.
	localparam int unsigned NUM_TRIG = 64; // Trigger lines, 0 unused.
	localparam int unsigned SEL_W = 6; // Width of a trigger select.
	localparam int unsigned ADDR_W = 8; // Register byte address width.
	localparam int unsigned OFS_W = 5; // Offset inside a channel block.

	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam logic [7:0] OFS_ENGINE = 8'h00; // engine_control.
	localparam logic [7:0] OFS_UPPER = 8'h04; // upper_ram_boundary.
	localparam logic [7:0] OFS_LOWER = 8'h08; // lower_ram_boundary.
	localparam logic [7:0] OFS_BUF = 8'h0c; // data_buffer.
	localparam logic [7:0] OFS_PWRDN = 8'h10; // Group power-down bits.
	localparam logic [7:0] CH_BASE = 8'h20; // First channel block.
	localparam logic [7:0] CH_STRIDE = 8'h20; // Channel block size.
	localparam logic [4:0] CH_CTRL = 5'h00; // channel_control.
	localparam logic [4:0] CH_INTC = 5'h04; // Interrupt control.
	localparam logic [4:0] CH_SRC = 5'h08; // source_pointer.
	localparam logic [4:0] CH_DST = 5'h0c; // destination_pointer.
	localparam logic [4:0] CH_CNT = 5'h10; // transaction_counter.

	// ****************************************************************
	// Field positions, masks and reset values
	// ****************************************************************
	localparam int unsigned EN_BIT = 15; // module_enable_bit.
	localparam int unsigned PRS_BIT = 0; // priority_scheme_select.
	localparam int unsigned CHANNEL_ENABLE_BIT_BIT = 0; // channel_enable_bit.
	localparam int unsigned SIZE_BIT = 1; // 1 selects byte items.
	localparam int unsigned TRM_LO = 2; // transfer_mode_field.
	localparam int unsigned DAM_LO = 4; // dest_address_mode.
	localparam int unsigned SAM_LO = 6; // source_address_mode.
	localparam int unsigned REQ_BIT = 8; // software_request_bit.
	localparam int unsigned RELOAD_BIT = 9; // Reload enable.
	localparam int unsigned NULL_WRITE_MODE_BIT = 10; // null_write_mode.
	localparam int unsigned INDIR_BIT = 11; // Indirect addressing.
	localparam int unsigned HALFEN_BIT = 0; // Halfway watermark enable.
	localparam int unsigned OVR_BIT = 3; // overrun_flag.
	localparam int unsigned HALF_BIT = 4; // Halfway flag.
	localparam int unsigned DONE_BIT = 5; // Completion flag.
	localparam int unsigned LOW_BIT = 6; // Low limit flag.
	localparam int unsigned HIGH_BIT = 7; // High limit flag.
	localparam int unsigned SEL_LO = 8; // Trigger select field.
	localparam int unsigned DBUF_BIT = 15; // Buffer not yet written.
	localparam int unsigned TRM_REP = 0; // Mode bit: repeated.
	localparam int unsigned TRM_CONT = 1; // Mode bit: continuous.
	localparam logic [15:0] ENG_MASK = 16'h8001;
	localparam logic [15:0] CTRL_MASK = 16'h0fff;
	localparam logic [15:0] INTC_MASK = 16'h3ff9;
	localparam logic [15:0] PWR_MASK = 16'h0003;
	localparam logic [15:0] UPPER_RST = 16'hffff;
	localparam logic [15:0] LOWER_RST = 16'h0800;
	localparam logic [15:0] SFR_TOP = 16'h07ff; // Last SFR address.
	localparam logic [1:0] AM_INC = 2'b01; // Address mode: increment.
	localparam logic [1:0] AM_DEC = 2'b10; // Address mode: decrement.
	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] STEP_WORD = 16'h0002;
	localparam logic [1:0] BE_LO = 2'b01;
	localparam logic [1:0] BE_HI = 2'b10;
	localparam logic [1:0] BE_ALL = 2'b11;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Engine sequencer states, one-hot.
	typedef enum logic [3:0] {
		MDC_IDLE = 4'b0001,
		MDC_READ = 4'b0010,
		MDC_WRITE = 4'b0100,
		MDC_NULL = 4'b1000
	} mdc_fsm_t;

endpackage

/* rtl/mdc_engine.sv */
/*
 * Multichannel transfer engine: AXI4-Lite register slave, channel
 * arbiter and a 16-bit memory master that moves bytes or words.
 * Assumes trigger lines come from another domain, the memory port and
 * the indirect offset are on aclk, and memory acks each request once.
 */
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.

// Functional notes
// - Size bit picks byte or word; word default.
// - Byte mode: address LSB picks the byte lane.
// - Per-channel trigger select from 63 sources.
// - Excluded sources are simply not wired in.
// - Mode field: one-shot, repeated, continuous, both.
// - One-shot one item; continuous until count zero.
// - Repeated modes always reload and stay enabled.
// - Reload bit restores pointers and count.
// - Source pointer holds, increments or decrements.
// - Destination pointer holds, increments or decrements.
// - Indirect mode adds peripheral offset to base.
// - Round robin: lowest first, then rotate upward.
// - Fixed priority: lowest requesting channel wins.
// - Engine bit 0 selects round robin.
// - Engine enable clear aborts all activity.
// - Channel acts only while enabled.
// - Null write mode writes source after destination.
// - Software request starts; cleared at completion.
// - Two power-down bits gate channel groups.
// - Five engine registers plus five per channel.
// - Out-of-bounds RAM access aborts and flags.
// - Below 0800h is SFR space, else RAM.
// - Trigger during pending work flags overrun.
module mdc_engine
	import mdc_pkg::*;
#(
	parameter int unsigned NCH = NUM_CH,
	parameter int unsigned AW = ADDR_W
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data.
	input wire logic [AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read.
	input wire logic [AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Peripheral trigger lines and indirect offset.
	input wire logic [NUM_TRIG-1:0] trig_in,
	input wire logic [15:0] periph_offset,
	// Data space master port.
	output logic mem_req,
	output logic mem_we,
	output logic [15:0] mem_addr,
	output logic [1:0] mem_be,
	output logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata,
	input wire logic mem_ack,
	// Per-channel event pulses.
	output logic [NCH-1:0] chan_done,
	output logic [NCH-1:0] chan_error
);

	// ****************************************************************
	// State
	// ****************************************************************
	localparam int unsigned CW = (NCH > 1) ? $clog2(NCH) : 1;

	// All flip-flops of the engine in one record.
	typedef struct packed {
		mdc_fsm_t fsm; // Sequencer state.
		logic [CW-1:0] cur; // Channel being served.
		logic [CW-1:0] last; // Last arbitration winner.
		logic [15:0] eng; // engine_control.
		logic [15:0] upper; // upper_ram_boundary.
		logic [15:0] lower; // lower_ram_boundary.
		logic [15:0] dbuf; // data_buffer.
		logic [15:0] pwr; // Group power-down bits.
		logic [NCH-1:0][15:0] ctrl; // channel_control.
		logic [NCH-1:0][15:0] intc; // Interrupt control and flags.
		logic [NCH-1:0][15:0] src; // Live source pointers.
		logic [NCH-1:0][15:0] dst; // Live destination pointers.
		logic [NCH-1:0][15:0] cnt; // Live counters.
		logic [NCH-1:0][15:0] src0; // Saved source pointers.
		logic [NCH-1:0][15:0] dst0; // Saved destination pointers.
		logic [NCH-1:0][15:0] cnt0; // Saved counters.
		logic [NCH-1:0] pend; // Trigger waiting for service.
		logic [NUM_TRIG-1:0] t1; // Synchroniser first stage.
		logic [NUM_TRIG-1:0] t2; // Synchroniser second stage.
		logic [NUM_TRIG-1:0] t3; // Previous level for edges.
		logic awready, wready, bvalid, arready, rvalid;
		logic [1:0] bresp, rresp;
		logic [31:0] rdata;
		logic mreq, mwe;
		logic [15:0] maddr, mwdata;
		logic [1:0] mbe;
		logic [NCH-1:0] done_p, err_p;
	} mdc_state_t;

	mdc_state_t s; // Registered state.
	mdc_state_t n; // Next state.

	// ****************************************************************
	// Functions
	// ****************************************************************
	// Splits a byte address into {hit, channel, offset in block}.
	function automatic logic [CW+OFS_W:0] f_decode(input logic [AW-1:0] a);
		logic [7:0] r;
		logic hit;
		r = 8'(a) - CH_BASE;
		hit = (8'(a) >= CH_BASE) && ((r / CH_STRIDE) < 8'(NCH));
		f_decode = {hit, CW'(r / CH_STRIDE), OFS_W'(r % CH_STRIDE)};
	endfunction

	// Applies the byte strobes and the writable-bit mask.
	function automatic logic [15:0] f_merge(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] st, input logic [15:0] m);
		logic [15:0] v;
		v = old;
		if (st[0]) begin
			v[7:0] = wd[7:0];
		end
		if (st[1]) begin
			v[15:8] = wd[15:8];
		end
		f_merge = v & m;
	endfunction

	// Byte lanes of an access: both for a word; for a byte the address LSB picks the lane.
	function automatic logic [1:0] f_be(input logic byte_mode,
		input logic a0);
		if (!byte_mode) begin
			f_be = BE_ALL;
		end else begin
			f_be = a0 ? BE_HI : BE_LO;
		end
	endfunction

	// Limit check on RAM addresses: {above upper, below lower}.
	function automatic logic [1:0] f_limit(input logic [15:0] a,
		input logic [15:0] up, input logic [15:0] lo);
		logic ram;
		ram = a > SFR_TOP;
		f_limit = {ram && (a > up), ram && (a < lo)};
	endfunction

	// Moves a pointer by one item according to its address mode.
	function automatic logic [15:0] f_step(input logic [15:0] p,
		input logic [1:0] md, input logic byte_mode);
		logic [15:0] st;
		st = byte_mode ? STEP_BYTE : STEP_WORD;
		if (md == AM_INC) begin
			f_step = p + st;
		end else if (md == AM_DEC) begin
			f_step = p - st;
		end else begin
			f_step = p;
		end
	endfunction

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	// Registers, triggers, arbitration and the transfer sequencer.
	always_comb begin
		logic [CW+OFS_W:0] dw, dr;
		logic [CW-1:0] c, w;
		logic [OFS_W-1:0] off;
		logic [NCH-1:0] act, req, hit, ctrl_wr;
		logic [NUM_TRIG-1:0] edge_v;
		logic [15:0] sa, da, cn, rd16;
		logic [1:0] lim;
		logic found, fin, bmode;
		int k;
		dw = '0;
		dr = '0;
		c = '0;
		w = '0;
		off = '0;
		act = '0;
		req = '0;
		hit = '0;
		ctrl_wr = '0;
		sa = '0;
		da = '0;
		cn = '0;
		rd16 = '0;
		lim = '0;
		found = 1'b0;
		fin = 1'b0;
		bmode = 1'b0;
		k = 0;
		n = s;
		n.done_p = '0;
		n.err_p = '0;

		// Two flip-flops before any logic reads a trigger line.
		n.t1 = trig_in;
		n.t2 = s.t1;
		n.t3 = s.t2;
		edge_v = s.t2 & ~s.t3;

		// Write channel: take address and data together, once.
		n.awready = !s.awready && !s.bvalid && s_axi_awvalid && s_axi_wvalid;
		n.wready = n.awready;
		if (s.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (s.awready) begin
			n.bvalid = 1'b1;
			n.bresp = RESP_OKAY;
			dw = f_decode(s_axi_awaddr);
			{c, off} = dw[CW+OFS_W-1:0];
			if (dw[CW+OFS_W]) begin
				case (off)
					CH_CTRL: begin
						n.ctrl[c] = f_merge(s.ctrl[c], s_axi_wdata, s_axi_wstrb,
							CTRL_MASK);
						ctrl_wr[c] = 1'b1;
					end
					CH_INTC: n.intc[c] = f_merge(s.intc[c], s_axi_wdata,
						s_axi_wstrb, INTC_MASK);
					CH_SRC: begin
						n.src[c] = f_merge(s.src[c], s_axi_wdata, s_axi_wstrb, '1);
						n.src0[c] = n.src[c];
					end
					CH_DST: begin
						n.dst[c] = f_merge(s.dst[c], s_axi_wdata, s_axi_wstrb, '1);
						n.dst0[c] = n.dst[c];
					end
					CH_CNT: begin
						n.cnt[c] = f_merge(s.cnt[c], s_axi_wdata, s_axi_wstrb, '1);
						n.cnt0[c] = n.cnt[c];
					end
					default: n.bresp = RESP_SLVERR;
				endcase
			end else begin
				case (8'(s_axi_awaddr))
					OFS_ENGINE: n.eng = f_merge(s.eng, s_axi_wdata, s_axi_wstrb,
						ENG_MASK);
					OFS_UPPER: n.upper = f_merge(s.upper, s_axi_wdata,
						s_axi_wstrb, '1);
					OFS_LOWER: n.lower = f_merge(s.lower, s_axi_wdata,
						s_axi_wstrb, '1);
					OFS_BUF: n.dbuf = f_merge(s.dbuf, s_axi_wdata, s_axi_wstrb, '1);
					OFS_PWRDN: n.pwr = f_merge(s.pwr, s_axi_wdata, s_axi_wstrb,
						PWR_MASK);
					default: n.bresp = RESP_SLVERR;
				endcase
			end
		end

		// Read channel: one beat, answered the cycle after the take.
		n.arready = !s.arready && !s.rvalid && s_axi_arvalid;
		if (s.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (s.arready) begin
			n.rvalid = 1'b1;
			n.rresp = RESP_OKAY;
			dr = f_decode(s_axi_araddr);
			{c, off} = dr[CW+OFS_W-1:0];
			if (dr[CW+OFS_W]) begin
				case (off)
					CH_CTRL: rd16 = s.ctrl[c];
					CH_INTC: rd16 = s.intc[c];
					CH_SRC: rd16 = s.src[c];
					CH_DST: rd16 = s.dst[c];
					CH_CNT: rd16 = s.cnt[c];
					default: n.rresp = RESP_SLVERR;
				endcase
			end else begin
				case (8'(s_axi_araddr))
					OFS_ENGINE: rd16 = s.eng;
					OFS_UPPER: rd16 = s.upper;
					OFS_LOWER: rd16 = s.lower;
					OFS_BUF: rd16 = s.dbuf;
					OFS_PWRDN: rd16 = s.pwr;
					default: n.rresp = RESP_SLVERR;
				endcase
			end
			n.rdata = {16'h0000, rd16};
		end

		// Channel qualification, trigger capture and overrun.
		for (int i = 0; i < NCH; i++) begin
			act[i] = s.eng[EN_BIT] && s.ctrl[i][CHANNEL_ENABLE_BIT_BIT] &&
				!((i < GROUP0_N) ? s.pwr[0] : s.pwr[1]);
			// Select zero means no trigger.
			hit[i] = (s.intc[i][SEL_LO +: SEL_W] != '0) &&
				edge_v[s.intc[i][SEL_LO +: SEL_W]];
			if (act[i] && hit[i]) begin
				if (s.pend[i] || (!s.fsm[0] && s.cur == CW'(i))) begin
					n.intc[i][OVR_BIT] = 1'b1;
				end
				n.pend[i] = 1'b1;
			end
			req[i] = act[i] && (s.pend[i] || s.ctrl[i][REQ_BIT]);
		end

		// Winner: lowest, or the next one above the last winner.
		for (int i = 0; i < NCH; i++) begin
			k = s.eng[PRS_BIT] ? ((int'(s.last) + 1 + i) % NCH) : i;
			if (!found && req[k]) begin
				found = 1'b1;
				w = CW'(k);
			end
		end

		// Effective addresses of the channel in service.
		c = s.cur;
		bmode = s.ctrl[c][SIZE_BIT];
		sa = s.ctrl[c][INDIR_BIT] ? s.src[c] + periph_offset : s.src[c];
		da = s.ctrl[c][INDIR_BIT] ? s.dst[c] + periph_offset : s.dst[c];

		// Transfer sequencer.
		case (s.fsm)
			MDC_IDLE: begin
				if (found) begin
					n.cur = w;
					n.last = w;
					c = w;
					bmode = s.ctrl[w][SIZE_BIT];
					sa = s.ctrl[w][INDIR_BIT] ? s.src[w] + periph_offset
						: s.src[w];
					lim = f_limit(sa, s.upper, s.lower);
					if (lim != '0) begin
						n.intc[w][HIGH_BIT] = n.intc[w][HIGH_BIT] | lim[1];
						n.intc[w][LOW_BIT] = n.intc[w][LOW_BIT] | lim[0];
						n.pend[w] = 1'b0;
						n.ctrl[w][REQ_BIT] = ctrl_wr[w] && n.ctrl[w][REQ_BIT];
						n.err_p[w] = 1'b1;
					end else begin
						n.mreq = 1'b1;
						n.mwe = 1'b0;
						n.maddr = sa;
						n.mbe = f_be(bmode, sa[0]);
						n.fsm = MDC_READ;
					end
				end
			end
			MDC_READ: begin
				if (mem_ack) begin
					// Byte items keep only the addressed lane.
					n.dbuf = !bmode ? mem_rdata : (sa[0] ?
						{8'h00, mem_rdata[15:8]} : {8'h00, mem_rdata[7:0]});
					n.intc[c][DBUF_BIT] = 1'b1;
					lim = f_limit(da, s.upper, s.lower);
					if (lim != '0) begin
						n.intc[c][HIGH_BIT] = n.intc[c][HIGH_BIT] | lim[1];
						n.intc[c][LOW_BIT] = n.intc[c][LOW_BIT] | lim[0];
						n.pend[c] = 1'b0;
						n.ctrl[c][REQ_BIT] = ctrl_wr[c] && n.ctrl[c][REQ_BIT];
						n.err_p[c] = 1'b1;
						n.mreq = 1'b0;
						n.fsm = MDC_IDLE;
					end else begin
						n.mwe = 1'b1;
						n.maddr = da;
						n.mbe = f_be(bmode, da[0]);
						n.mwdata = bmode ? {n.dbuf[7:0], n.dbuf[7:0]} : n.dbuf;
						n.fsm = MDC_WRITE;
					end
				end
			end
			MDC_WRITE: begin
				if (mem_ack) begin
					if (s.ctrl[c][NULL_WRITE_MODE_BIT]) begin
						n.maddr = sa;
						n.mbe = f_be(bmode, sa[0]);
						n.fsm = MDC_NULL;
					end else begin
						fin = 1'b1;
					end
				end
			end
			MDC_NULL: begin
				if (mem_ack) begin
					fin = 1'b1;
				end
			end
			default: n.fsm = MDC_IDLE;
		endcase

		// End of one item: step pointers, count, finish the session.
		if (fin) begin
			n.mreq = 1'b0;
			n.mwe = 1'b0;
			n.fsm = MDC_IDLE;
			n.intc[c][DBUF_BIT] = 1'b0;
			n.src[c] = f_step(s.src[c], s.ctrl[c][SAM_LO +: 2], bmode);
			n.dst[c] = f_step(s.dst[c], s.ctrl[c][DAM_LO +: 2], bmode);
			cn = s.cnt[c] - 16'h0001;
			n.cnt[c] = cn;
			if (s.intc[c][HALFEN_BIT] && cn == (s.cnt0[c] >> 1)) begin
				n.intc[c][HALF_BIT] = 1'b1;
			end
			// One-shot ends the trigger now, continuous at zero.
			if (!s.ctrl[c][TRM_LO + TRM_CONT] || cn == '0) begin
				n.pend[c] = 1'b0;
				n.ctrl[c][REQ_BIT] = ctrl_wr[c] && n.ctrl[c][REQ_BIT];
			end
			if (cn == '0) begin
				n.intc[c][DONE_BIT] = 1'b1;
				n.done_p[c] = 1'b1;
				if (s.ctrl[c][RELOAD_BIT] || s.ctrl[c][TRM_LO + TRM_REP]) begin
					n.src[c] = s.src0[c];
					n.dst[c] = s.dst0[c];
					n.cnt[c] = s.cnt0[c];
				end
				if (!s.ctrl[c][TRM_LO + TRM_REP]) begin
					n.ctrl[c][CHANNEL_ENABLE_BIT_BIT] = ctrl_wr[c] && n.ctrl[c][CHANNEL_ENABLE_BIT_BIT];
				end
			end
		end

		// Engine disable drops all work at once.
		if (!s.eng[EN_BIT]) begin
			n.pend = '0;
			n.mreq = 1'b0;
			n.mwe = 1'b0;
			n.fsm = MDC_IDLE;
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	// Synchronous reset to the documented power-on values.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.fsm <= MDC_IDLE;
			s.upper <= UPPER_RST;
			s.lower <= LOWER_RST;
			s.last <= CW'(NCH - 1);
		end else begin
			s <= n;
		end
	end

	// ****************************************************************
	// Outputs, all straight from the state register
	// ****************************************************************
	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign mem_req = s.mreq;
	assign mem_we = s.mwe;
	assign mem_addr = s.maddr;
	assign mem_be = s.mbe;
	assign mem_wdata = s.mwdata;
	assign chan_done = s.done_p;
	assign chan_error = s.err_p;

endmodule

/* bench/mdc_engine_assertions.sv */
/* Port checker of the transfer engine.
   Assumes it is bound into mdc_engine and sees its ports only. */
module mdc_engine_assertions
	import mdc_pkg::*;
(
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus.
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Memory port.
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [1:0] mem_be,
	input wire logic [15:0] mem_wdata,
	input wire logic mem_ack
);
	// ****
	// Properties
	// ****
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// A write taken on both channels in one cycle.
	sequence wr_taken;
		s_axi_awready && s_axi_wready;
	endsequence
	// A memory request left waiting for its answer.
	sequence mem_wait;
		mem_req && !mem_ack ##1 mem_req;
	endsequence
	chk_aw_w_pair: assert property (s_axi_awready |-> s_axi_wready)
		else $error("address taken without data");
	chk_resp_follows: assert property (wr_taken |=> s_axi_bvalid)
		else $error("no write response after handshake");
	chk_resp_holds: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid)
		else $error("write response dropped early");
	chk_rd_follows: assert property (s_axi_arready |=> s_axi_rvalid)
		else $error("no read data after address");
	chk_rd_holds: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before taken");
	chk_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 0)
		else $error("upper read half not zero");
	chk_mem_holds: assert property (mem_wait |-> $stable(mem_addr)
		&& $stable(mem_we) && $stable(mem_be))
		else $error("memory request changed before ack");
	chk_byte_lane: assert property (mem_req && mem_be != BE_ALL
		|-> mem_be == (mem_addr[0] ? BE_HI : BE_LO))
		else $error("byte lane does not follow address bit");
	chk_byte_copy: assert property (mem_req && mem_we && mem_be != BE_ALL
		|-> mem_wdata[15:8] == mem_wdata[7:0])
		else $error("byte not on both lanes");
endmodule

bind mdc_engine mdc_engine_assertions chk_u (.aclk, .aresetn,
	.s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
	.mem_req, .mem_we, .mem_addr, .mem_be, .mem_wdata, .mem_ack);

/* bench/mdc_mem_model.sv */
/* Byte-wide data space behind the engine memory port.
   Assumes each request holds until acked; slow adds wait cycles. */
module mdc_mem_model
	import mdc_pkg::*;
(
	// Clock and pace.
	input wire logic aclk,
	input wire logic slow,
	// Memory port.
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [1:0] mem_be,
	input wire logic [15:0] mem_wdata,
	output logic [15:0] mem_rdata,
	output logic mem_ack
);
	logic [7:0] m [0:65535]; // Data space bytes.
	logic [1:0] wt = 2'b00; // Wait cycles left.
	logic [15:0] a; // Word address.
	assign a = {mem_addr[15:1], 1'b0};
	initial mem_ack = 1'b0;
	initial mem_rdata = 16'h0000;
	// One answer per request; stale read data toggles every cycle.
	always @(posedge aclk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack && wt != 0) begin
			wt <= wt - 2'd1;
		end else if (mem_req && !mem_ack) begin
			mem_ack <= 1'b1;
			wt <= {slow, slow};
			if (mem_we && mem_be[0]) m[a] <= mem_wdata[7:0];
			if (mem_we && mem_be[1]) m[a + 16'd1] <= mem_wdata[15:8];
			if (!mem_we) mem_rdata <= {m[a + 16'd1], m[a]};
		end
	end
endmodule

/* bench/mdc_engine_test.sv */
/* Self-checking bench of the transfer engine.
   Assumes the package register map and the data space model. */
module mdc_engine_test
	import mdc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic aclk = 0, aresetn = 0, slow = 0;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, mem_req, mem_we, mem_ack;
	logic [1:0] s_axi_bresp, s_axi_rresp, mem_be, r;
	logic [15:0] mem_addr, mem_wdata, mem_rdata, seed, d, c, s, t;
	logic [63:0] trig_in;
	logic [5:0] dn_p, dn = '0; // Done pulses and their sticky record.
	logic [7:0] ref_m [0:65535]; // Expected data space.
	int failures = 0, comparisons = 0, n, i, k, j, cnt, step, e;
	always #2.5 aclk = ~aclk;
	always @(posedge aclk) dn <= dn | dn_p;
	mdc_engine #(.NCH(NUM_CH), .AW(ADDR_W)) dut_u (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .trig_in, .periph_offset(16'h0000), .mem_req,
		.mem_we, .mem_addr, .mem_be, .mem_wdata, .mem_rdata, .mem_ack,
		.chan_done(dn_p), .chan_error());
	mdc_mem_model mem_u (.aclk, .slow, .mem_req, .mem_we, .mem_addr,
		.mem_be, .mem_wdata, .mem_rdata, .mem_ack);
	// ****
	// Helpers
	// ****
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function automatic logic [7:0] ra(input int ch, input logic [4:0] o);
		return CH_BASE + CH_STRIDE * 8'(ch) + {3'b000, o};
	endfunction
	task automatic test_done();
		$display("Comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// A wait that ran out counts as a mismatch.
	task automatic tmo();
		failures++;
		test_done();
	endtask
	task automatic chk_val(input string nm, input logic [15:0] x,
		input logic [15:0] g);
		comparisons++;
		if (g !== x) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic chk_resp(input logic [1:0] x, input logic [1:0] g);
		comparisons++;
		if (g !== x) begin
			failures++;
			$display("Error response expected %h seen %h", x, g);
		end
	endtask
	// Register write; bready stands from the start until bvalid.
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, v};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 100);
		chk_resp(RESP_OKAY, s_axi_bresp);
		if (n >= 100) tmo();
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	// Register read; rready stands from the start until rvalid.
	task automatic rd(input logic [7:0] a);
		n = 0;
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 100);
		d = s_axi_rdata[15:0];
		r = s_axi_rresp;
		if (n >= 100) tmo();
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	// Poll a channel control bit until hardware clears it.
	task automatic poll(input int ch, input int b);
		for (j = 0; j < 40; j++) begin
			rd(ra(ch, CH_CTRL));
			if (!d[b]) break;
		end
		if (d[b]) tmo();
	endtask
	initial begin
		repeat (90000) @(posedge aclk);
		tmo();
	end
	// ****
	// Main sequence
	// ****
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
		{s_axi_arvalid, s_axi_rready} = 2'b00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		trig_in = '0;
		seed = 16'h0002;
		for (i = 0; i < 65536; i++) begin
			seed = lfsr(seed);
			mem_u.m[i] = seed[7:0];
			ref_m[i] = seed[7:0];
		end
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(OFS_UPPER);
		chk_val("upper", UPPER_RST, d);
		rd(OFS_LOWER);
		chk_val("lower", LOWER_RST, d);
		rd(ra(0, CH_CTRL));
		chk_val("control reset", 16'h0000, d);
		rd(8'hfc);
		chk_resp(RESP_SLVERR, r);
		wr(OFS_ENGINE, 16'h8000);
		for (k = 0; k < 6; k++) begin
			seed = lfsr(seed);
			slow <= seed[0];
			cnt = (k < 4) ? 3 : 1;
			step = (k % 2) ? 1 : 2;
			s = 16'h0920 + 16'(k * 64 + k % 2);
			t = 16'h0c20 + 16'(k * 64);
			c = 16'((k % 3) << 6 | ((k + 1) % 3) << 4 | (k % 4) << 2);
			c = c | 16'((k % 2) << 1 | 1);
			c[RELOAD_BIT] = (k == 4);
			wr(ra(k, CH_SRC), s);
			wr(ra(k, CH_DST), t);
			wr(ra(k, CH_CNT), 16'(cnt));
			wr(ra(k, CH_CTRL), c);
			wr(ra(k, CH_CTRL), c | 16'h0100);
			poll(k, REQ_BIT);
			e = c[3] ? 0 : cnt - 1;
			if (e == 0 && !c[2]) c[CHANNEL_ENABLE_BIT_BIT] = 1'b0;
			chk_val("control", c, d);
			for (j = 0; j < (c[3] ? cnt : 1); j++) begin
				ref_m[t] = ref_m[s];
				if (step == 2) ref_m[t + 1] = ref_m[s + 1];
				s = s + 16'(c[7:6] == AM_INC ? step : c[7:6] == AM_DEC ? -step : 0);
				t = t + 16'(c[5:4] == AM_INC ? step : c[5:4] == AM_DEC ? -step : 0);
			end
			if (e == 0 && (c[2] || c[RELOAD_BIT])) begin
				s = 16'h0920 + 16'(k * 64 + k % 2);
				t = 16'h0c20 + 16'(k * 64);
				e = cnt;
			end
			for (i = 'h0c00 + k * 64; i < 'h0c40 + k * 64; i++)
				chk_val("memory", 16'(ref_m[i]), 16'(mem_u.m[i]));
			rd(ra(k, CH_SRC));
			chk_val("source", s, d);
			rd(ra(k, CH_DST));
			chk_val("destination", t, d);
			rd(ra(k, CH_CNT));
			chk_val("counter", 16'(e), d);
			wr(ra(k, CH_CTRL), 16'h0000);
		end
		for (k = 0; k < 2; k++) begin
			wr(ra(k, CH_SRC), 16'h1000 + 16'(k * 256));
			wr(ra(k, CH_DST), 16'h1200 + 16'(k * 256));
			wr(ra(k, CH_CNT), 16'h0001);
			wr(ra(k, CH_INTC), 16'h0500);
			wr(ra(k, CH_CTRL), 16'h0041);
		end
		trig_in[5] <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!mem_req && n < 50);
		if (!mem_req) tmo();
		chk_val("first winner", 16'h1000, mem_addr);
		poll(1, CHANNEL_ENABLE_BIT_BIT);
		chk_val("done", 16'h003f, 16'(dn));
		trig_in[5] <= 1'b0;
		test_done();
	end
endmodule
